//--- ddrtim_bank.sv
// ddrtim_bank.sv: one bank's open/precharge timing tracker
// assumes strobes are already synchronised to clock_i
`timescale 1ns/1ps
module ddrtim_bank (
   input  wire logic clock_i,
   input  wire logic nrst_i,
   input  wire logic act_i,
   input  wire logic rd_ap_i,
   input  wire logic wr_ap_i,
   input  wire logic pre_i,
   output logic      open_o,
   output logic      pre_fire_o
);
   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_OPEN = 3'h2,
      S_WAIT = 3'h4
   } ddrtim_bank_st_t;

   ddrtim_bank_st_t                      st;
   ddrtim_bank_st_t                      next_st;
   logic [ddrtim_pkg::CNT_W-1:0]         ras_cnt;
   logic [ddrtim_pkg::CNT_W-1:0]         next_ras_cnt;
   logic [ddrtim_pkg::CNT_W-1:0]         rtp_cnt;
   logic [ddrtim_pkg::CNT_W-1:0]         next_rtp_cnt;
   logic                                 next_pre_fire;

   // ----------------------------------------------------------------
   // next state: auto precharge locked out until both counts expire
   // ----------------------------------------------------------------
   always_comb begin
      next_st       = st;
      next_pre_fire = 1'b0;
      next_ras_cnt  = (ras_cnt != '0) ? ras_cnt - 1'b1 : ras_cnt;
      next_rtp_cnt  = (rtp_cnt != '0) ? rtp_cnt - 1'b1 : rtp_cnt;
      case (st)
         S_IDLE: begin
            if (act_i) begin
               next_st      = S_OPEN;
               next_ras_cnt = ddrtim_pkg::CNT_W'(ddrtim_pkg::ACT_TO_PRE_MIN_CYC);
            end
         end
         S_OPEN: begin
            if (pre_i) begin
               next_st = S_IDLE;
            end else if (rd_ap_i || wr_ap_i) begin  // early issue accepted
               next_st = S_WAIT;
               if (rd_ap_i) begin
                  next_rtp_cnt = ddrtim_pkg::CNT_W'(ddrtim_pkg::RD_TO_PRE_CYC);
               end
            end
         end
         S_WAIT: begin
            if (next_ras_cnt == '0 && next_rtp_cnt == '0) begin
               next_st       = S_IDLE;
               next_pre_fire = 1'b1;
            end
         end
         default: next_st = S_IDLE;
      endcase
   end

   // registers
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         st         <= S_IDLE;
         ras_cnt    <= '0;
         rtp_cnt    <= '0;
         pre_fire_o <= 1'b0;
      end else begin
         st         <= next_st;
         ras_cnt    <= next_ras_cnt;
         rtp_cnt    <= next_rtp_cnt;
         pre_fire_o <= next_pre_fire;
      end
   end

   assign open_o = (st != S_IDLE);

   // internal precharge never before active minimum
   a_pre_after_ras: assert property (@(posedge clock_i) disable iff (!nrst_i)
      pre_fire_o |-> $past(ras_cnt) <= 1) else $error("precharge before active minimum");
   a_early_ap_ok: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (st == S_OPEN && (rd_ap_i || wr_ap_i) && !pre_i) |=> st == S_WAIT)
      else $error("early auto precharge refused");
endmodule

//--- ddrtim_core.sv
// ddrtim_core.sv: device side command timing, refresh and termination control
// assumes memory clock and command pins are asynchronous to clock_i
`timescale 1ns/1ps
module ddrtim_core (
   input  wire logic                   clock_i,
   input  wire logic                   nrst_i,
   input  wire logic                   mem_clk_i,
   input  wire logic                   clock_enable_i,
   input  wire logic                   termination_control_i,
   input  wire ddrtim_pkg::ddrtim_cmd_t cmd_i,
   output logic [7:0]                  bank_open_o,
   output logic                        internal_pre_o,
   output logic                        refresh_o,
   output logic [15:0]                 refresh_count_o,
   output logic                        cke_registered_o,
   output ddrtim_pkg::ddrtim_term_t    term_sel_o,
   output logic                        term_on_o
);
   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   ddrtim_pkg::ddrtim_cmd_t cmd_s1;
   ddrtim_pkg::ddrtim_cmd_t cmd_s2;
   logic [2:0]              lvl_s1;
   logic [2:0]              lvl_s2;
   logic                    clk_d;
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         cmd_s1 <= '1;
         cmd_s2 <= '1;
         lvl_s1 <= 3'h0;
         lvl_s2 <= 3'h0;
         clk_d  <= 1'b0;
      end else begin
         cmd_s1 <= cmd_i;
         cmd_s2 <= cmd_s1;
         lvl_s1 <= {mem_clk_i, clock_enable_i, termination_control_i};
         lvl_s2 <= lvl_s1;
         clk_d  <= lvl_s2[2];
      end
   end

   logic clk_rise;
   logic clk_edge;
   logic cke_s;
   logic odt_s;
   assign clk_rise = lvl_s2[2] && !clk_d;
   assign clk_edge = lvl_s2[2] ^ clk_d;
   assign cke_s    = lvl_s2[1];
   assign odt_s    = lvl_s2[0];

   // ----------------------------------------------------------------
   // command decode on memory clock rising edges
   // ----------------------------------------------------------------
   logic cke_q;
   logic valid;
   logic is_act;
   logic is_rd;
   logic is_wr;
   logic is_pre;
   logic is_ref;
   logic is_mrs;
   logic ap;
   assign valid  = clk_rise && cke_q && !cmd_s2.cs_n;
   assign is_act = valid && cmd_s2.cmd == ddrtim_pkg::CMD_ACT;
   assign is_rd  = valid && cmd_s2.cmd == ddrtim_pkg::CMD_RD;
   assign is_wr  = valid && cmd_s2.cmd == ddrtim_pkg::CMD_WR;
   assign is_pre = valid && cmd_s2.cmd == ddrtim_pkg::CMD_PRE;
   assign is_ref = valid && cmd_s2.cmd == ddrtim_pkg::CMD_REF;
   assign is_mrs = valid && cmd_s2.cmd == ddrtim_pkg::CMD_MRS;
   assign ap     = cmd_s2.addr[ddrtim_pkg::ADDR_AP_BIT];

   // one tracker per bank; precharge-all hits every bank
   logic [7:0] bank_fire;
   for (genvar b = 0; b < 8; b++) begin : g_bank
      logic hit;
      assign hit = (cmd_s2.bank == 3'(b));
      ddrtim_bank u_bank (
         .clock_i    (clock_i),
         .nrst_i     (nrst_i),
         .act_i      (is_act && hit),
         .rd_ap_i    (is_rd && ap && hit),
         .wr_ap_i    (is_wr && ap && hit),
         .pre_i      (is_pre && (hit || ap)),
         .open_o     (bank_open_o[b]),
         .pre_fire_o (bank_fire[b])
      );
   end
   assign internal_pre_o = |bank_fire;

   // ----------------------------------------------------------------
   // refresh: every command accepted, bursts allowed
   // ----------------------------------------------------------------
   logic [15:0] next_refresh_count;
   logic        next_refresh;
   always_comb begin
      next_refresh       = is_ref;  // no spacing check
      next_refresh_count = is_ref ? refresh_count_o + 16'h0001 : refresh_count_o;
   end

   // ----------------------------------------------------------------
   // clock enable registration, three consecutive edges
   // ----------------------------------------------------------------
   logic [1:0] cke_run;
   logic [1:0] next_cke_run;
   logic       next_cke_q;
   logic       next_cke_reg;
   always_comb begin
      next_cke_q   = cke_q;
      next_cke_run = cke_run;
      next_cke_reg = cke_registered_o;
      if (clk_rise) begin
         next_cke_q = cke_s;
         if (cke_s != cke_registered_o) begin
            next_cke_run = (cke_run == 2'h2) ? 2'h0 : cke_run + 2'h1;
            if (cke_run == 2'h2) begin
               next_cke_reg = cke_s;
            end
         end else begin
            next_cke_run = 2'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // termination select and turn-off delay
   // ----------------------------------------------------------------
   ddrtim_pkg::ddrtim_term_t next_term_sel;
   logic                     next_term_on;
   logic [2:0]               off_cnt;
   logic [2:0]               next_off_cnt;
   logic                     odt_q;
   logic                     next_odt_q;
   always_comb begin
      next_term_sel = term_sel_o;
      next_term_on  = term_on_o;
      next_off_cnt  = off_cnt;
      next_odt_q    = odt_q;
      // request registered on memory clock rises only
      if (clk_rise) begin
         next_odt_q = odt_s;
      end
      if (is_mrs && cmd_s2.bank == ddrtim_pkg::BANK_EXT) begin
         next_term_sel = ddrtim_pkg::ddrtim_term_t'({cmd_s2.addr[ddrtim_pkg::TERM_HI_BIT],
                                                     cmd_s2.addr[ddrtim_pkg::TERM_LO_BIT]});
      end
      if (term_sel_o == ddrtim_pkg::DDRTIM_TERM_OFF) begin
         next_term_on = 1'b0;
         next_off_cnt = 3'h0;
      end else if (odt_q) begin
         next_term_on = 1'b1;
         next_off_cnt = 3'h0;
      end else if (term_on_o && clk_edge) begin  // half periods
         next_off_cnt = off_cnt + 3'h1;
         if (off_cnt == ddrtim_pkg::TERM_OFF_HALVES - 3'h1) begin
            next_term_on = 1'b0;
            next_off_cnt = 3'h0;
         end
      end
   end

   // registers
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         refresh_o        <= 1'b0;
         refresh_count_o  <= 16'h0000;
         cke_q            <= 1'b0;
         cke_run          <= 2'h0;
         cke_registered_o <= 1'b0;
         term_sel_o       <= ddrtim_pkg::DDRTIM_TERM_OFF;
         term_on_o        <= 1'b0;
         off_cnt          <= 3'h0;
         odt_q            <= 1'b0;
      end else begin
         refresh_o        <= next_refresh;
         refresh_count_o  <= next_refresh_count;
         cke_q            <= next_cke_q;
         cke_run          <= next_cke_run;
         cke_registered_o <= next_cke_reg;
         term_sel_o       <= next_term_sel;
         term_on_o        <= next_term_on;
         off_cnt          <= next_off_cnt;
         odt_q            <= next_odt_q;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_ref_burst_ok: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_ref |=> refresh_o && refresh_count_o == $past(refresh_count_o) + 16'h0001)
      else $error("refresh not counted");
   a_term_disable: assert property (@(posedge clock_i) disable iff (!nrst_i)
      term_sel_o == ddrtim_pkg::DDRTIM_TERM_OFF |=> !term_on_o)
      else $error("termination on while disabled");
   a_term_sel_load: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (is_mrs && cmd_s2.bank == ddrtim_pkg::BANK_EXT && cmd_s2.addr[6] && !cmd_s2.addr[2])
      |=> term_sel_o == ddrtim_pkg::DDRTIM_TERM_150)
      else $error("termination select wrong");
   a_term_75_load: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (is_mrs && cmd_s2.bank == ddrtim_pkg::BANK_EXT && !cmd_s2.addr[6] && cmd_s2.addr[2])
      |=> term_sel_o == ddrtim_pkg::DDRTIM_TERM_75)
      else $error("termination select not 75 ohm");
   a_term_50_load: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (is_mrs && cmd_s2.bank == ddrtim_pkg::BANK_EXT && cmd_s2.addr[6] && cmd_s2.addr[2])
      |=> term_sel_o == ddrtim_pkg::DDRTIM_TERM_50)
      else $error("termination select not 50 ohm");
   a_term_off_load: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (is_mrs && cmd_s2.bank == ddrtim_pkg::BANK_EXT && !cmd_s2.addr[6] && !cmd_s2.addr[2])
      |=> term_sel_o == ddrtim_pkg::DDRTIM_TERM_OFF)
      else $error("termination select not off");
   a_term_on_req: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (odt_q && term_sel_o != ddrtim_pkg::DDRTIM_TERM_OFF) |=> term_on_o)
      else $error("termination request not honoured");
   a_term_off_delay: assert property (@(posedge clock_i) disable iff (!nrst_i)
      $fell(term_on_o) && $past(term_sel_o) != ddrtim_pkg::DDRTIM_TERM_OFF
      |-> $past(off_cnt) == 3'h4)
      else $error("termination off too early");
   a_cke_three_edges: assert property (@(posedge clock_i) disable iff (!nrst_i)
      $changed(cke_registered_o) |-> $past(cke_run) == 2'h2 && $past(clk_rise))
      else $error("clock enable taken early");
endmodule

//--- ddrtim_core_tb.sv
// ddrtim_core_tb.sv: self-checking bench of the command timing core
// assumes the controller model drives every pin of the device but clock_i and nrst_i
`timescale 1ns/1ps
module ddrtim_core_tb;
   logic                      clock_i;
   logic                      nrst_i;
   logic                      mem_clk;
   logic                      cke;
   logic                      term_pin;
   ddrtim_pkg::ddrtim_cmd_t   cmd;
   logic [7:0]                bank_open;
   logic                      internal_pre;
   logic                      refresh;
   logic [15:0]               refresh_count;
   logic                      cke_registered;
   ddrtim_pkg::ddrtim_term_t  term_sel;
   logic                      term_on;
   int                        n_errors = 0;
   int                        samples_checked = 0;
   int                        cycles = 0;
   int                        pre_pulses = 0;
   int                        ref_pulses = 0;

   ddrtim_core ddrtim_core_inst (.clock_i(clock_i), .nrst_i(nrst_i), .mem_clk_i(mem_clk),
      .clock_enable_i(cke), .termination_control_i(term_pin), .cmd_i(cmd),
      .bank_open_o(bank_open), .internal_pre_o(internal_pre), .refresh_o(refresh),
      .refresh_count_o(refresh_count), .cke_registered_o(cke_registered),
      .term_sel_o(term_sel), .term_on_o(term_on));
   ddrtim_ctrl_model ddrtim_ctrl_model_inst (.mem_clk_o(mem_clk), .clock_enable_o(cke),
      .termination_control_o(term_pin), .cmd_o(cmd));

   // ----------------------------------------------------------------
   // clock, pulse counters and hang limit
   // ----------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (internal_pre === 1'b1) pre_pulses <= pre_pulses + 1;
      if (refresh === 1'b1) ref_pulses <= ref_pulses + 1;
      if (cycles == 30000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic settle();
      repeat (12) @(posedge clock_i);
   endtask
   // three refreshes back to back all counted
   task automatic t_refresh();
      logic [15:0] base;
      int          base_p;
      wait (ddrtim_ctrl_model_inst.refresh_due === 1'b1);
      base = refresh_count;
      base_p = ref_pulses;
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_REF, 3'h0, 14'h0, 3);
      settle();
      check(refresh_count, base + 16'h3);
      check(16'(ref_pulses - base_p), 16'h3);
   endtask
   // with clock-enable low a refresh is ignored
   task automatic t_cke();
      logic [15:0] base;
      base = refresh_count;
      ddrtim_ctrl_model_inst.set_cke(1'b0);
      settle();
      check(16'(cke_registered), 16'h0);
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_REF, 3'h0, 14'h0, 1);
      settle();
      check(refresh_count, base);
      ddrtim_ctrl_model_inst.set_cke(1'b1);
      settle();
      check(16'(cke_registered), 16'h1);
   endtask
   // plain read keeps the bank, read with auto precharge closes it once
   task automatic t_autopre();
      int base_p;
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_ACT, 3'h2, 14'h0, 1);
      settle();
      check(16'(bank_open), 16'h0004);
      base_p = pre_pulses;
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_RD, 3'h2, 14'h0, 1);
      settle();
      check(16'(bank_open), 16'h0004);
      check(16'(pre_pulses - base_p), 16'h0);
      ddrtim_ctrl_model_inst.read_to_pre_gap();
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_RD, 3'h2, 14'h0400, 1);
      for (int i = 0; i < 40 && internal_pre !== 1'b1; i++) @(posedge clock_i);
      settle();
      check(16'(pre_pulses - base_p), 16'h1);
      check(16'(bank_open), 16'h0000);
   endtask
   // write with auto precharge closes the bank within the total delay
   task automatic t_wr_ap();
      int base_p;
      base_p = pre_pulses;
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_ACT, 3'h6, 14'h0, 1);
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_WR, 3'h6, 14'h0400, 1);
      ddrtim_ctrl_model_inst.ap_write_gap();
      check(16'(pre_pulses - base_p), 16'h1);
      check(16'(bank_open), 16'h0000);
   endtask
   // two banks opened apart, one precharge-all closes both
   task automatic t_pre_all();
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_ACT, 3'h1, 14'h0, 1);
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_ACT, 3'h5, 14'h0, 1);
      settle();
      check(16'(bank_open), 16'h0022);
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_PRE, 3'h0, 14'h0400, 1);
      settle();
      check(16'(bank_open), 16'h0000);
      repeat (16) @(posedge clock_i); // all-bank period plus a clock
   endtask
   // termination selects, disabled state and the turn-off delay
   task automatic t_term();
      logic [13:0] a;
      ddrtim_pkg::ddrtim_term_t tab [4];
      tab = '{ddrtim_pkg::DDRTIM_TERM_OFF, ddrtim_pkg::DDRTIM_TERM_75,
              ddrtim_pkg::DDRTIM_TERM_150, ddrtim_pkg::DDRTIM_TERM_50};
      for (int i = 3; i >= 0; i--) begin
         a = 14'h0;
         a[ddrtim_pkg::TERM_HI_BIT] = i[1];
         a[ddrtim_pkg::TERM_LO_BIT] = i[0];
         ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_MRS, ddrtim_pkg::BANK_EXT, a, 1);
         settle();
         check(16'(term_sel), 16'(tab[i]));
      end
      ddrtim_ctrl_model_inst.set_term(1'b1);
      repeat (20) @(posedge clock_i);
      check(16'(term_on), 16'h0);
      ddrtim_ctrl_model_inst.send(ddrtim_pkg::CMD_MRS, ddrtim_pkg::BANK_EXT, 14'h0004, 1);
      settle();
      check(16'(term_on), 16'h1);
      ddrtim_ctrl_model_inst.set_term(1'b0);
      repeat (22) @(posedge clock_i);
      check(16'(term_on), 16'h1);
      repeat (8) @(posedge clock_i);
      check(16'(term_on), 16'h0);
   endtask

   task automatic summarize();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      nrst_i = 1'b0;
      repeat (12) @(posedge clock_i);
      #1 nrst_i = 1'b1;
      check(16'(bank_open), 16'h0000);
      check(16'(term_sel), 16'h0000);
      ddrtim_ctrl_model_inst.set_cke(1'b1);
      t_refresh();
      t_cke();
      t_autopre();
      t_pre_all();
      t_wr_ap();
      t_term();
      ddrtim_ctrl_model_inst.stop_clock();
      summarize();
   end
endmodule

//--- ddrtim_ctrl_model.sv
// ddrtim_ctrl_model.sv: behavioural memory controller on the device pins
// assumes the bench calls its tasks one at a time; memory clock period 80 ns
`timescale 1ns/1ps
module ddrtim_ctrl_model (
   output logic                    mem_clk_o,
   output logic                    clock_enable_o,
   output logic                    termination_control_o,
   output ddrtim_pkg::ddrtim_cmd_t cmd_o
);
   logic run;
   // ----------------------------------------------------------------
   // controller spacing in memory clocks; latencies are plain defaults
   // ----------------------------------------------------------------
   localparam int MEM_CLK_PERIOD_NS       = 80;
   localparam int ADDITIVE_LATENCY        = 0;
   localparam int BURST_LENGTH            = 4;
   // read-to-precharge time is two memory clocks here
   localparam int RD_TO_PRE_GAP           = ADDITIVE_LATENCY + BURST_LENGTH / 2;
   localparam int WRITE_RECOVERY_CLOCKS   = 4;
   localparam int PRECHARGE_PERIOD_NS     = 15;
   // recovery clocks plus precharge period rounded up
   localparam int AP_WRITE_TOTAL_DELAY    = WRITE_RECOVERY_CLOCKS +
      (PRECHARGE_PERIOD_NS + MEM_CLK_PERIOD_NS - 1) / MEM_CLK_PERIOD_NS;
   // 8192 refreshes per 64 ms, commercial grade, rounded down
   localparam int REFRESH_INTERVAL_CLOCKS = 64000000 / 8192 / MEM_CLK_PERIOD_NS;

   // refresh interval counter, restarted by each refresh
   int   refresh_timer = 0;
   logic refresh_due;
   always @(posedge mem_clk_o) begin
      if (!cmd_o.cs_n && cmd_o.cmd == ddrtim_pkg::CMD_REF) begin
         refresh_timer <= 0;
      end else if (refresh_timer < REFRESH_INTERVAL_CLOCKS) begin
         refresh_timer <= refresh_timer + 1;
      end
   end
   assign refresh_due = (refresh_timer == REFRESH_INTERVAL_CLOCKS);
   // ----------------------------------------------------------------
   // memory clock, stands low once stopped
   // ----------------------------------------------------------------
   initial begin
      mem_clk_o = 1'b0;
      run = 1'b1;
      clock_enable_o = 1'b0;
      termination_control_o = 1'b0;
      cmd_o = {1'b1, 3'h7, 3'h0, 14'h0};
      #3;
      forever begin
         #40;
         if (run || mem_clk_o) mem_clk_o = ~mem_clk_o;
      end
   end
   // command held over n rising edges, then deselected with scrambled lines
   // refreshes may go back to back with n above one
   task automatic send(input logic [2:0] cmd, input logic [2:0] bank,
                       input logic [13:0] addr, input int n);
      @(negedge mem_clk_o);
      cmd_o = {1'b0, cmd, bank, addr};
      repeat (n) @(negedge mem_clk_o);
      cmd_o = {1'b1, ~cmd, ~bank, ~addr};
   endtask
   // new level held over three registering edges
   task automatic set_cke(input logic v);
      @(negedge mem_clk_o);
      clock_enable_o = v;
      repeat (3) @(posedge mem_clk_o);
      @(negedge mem_clk_o);
   endtask
   task automatic set_term(input logic v);
      @(negedge mem_clk_o);
      termination_control_o = v;
   endtask
   // clock-enable low held over one rising edge before the clock is removed
   task automatic stop_clock();
      @(negedge mem_clk_o);
      clock_enable_o = 1'b0;
      @(posedge mem_clk_o);
      @(negedge mem_clk_o);
      run = 1'b0;
   endtask
   // spacing after a read before its precharge
   task automatic read_to_pre_gap();
      repeat (RD_TO_PRE_GAP) @(negedge mem_clk_o);
   endtask
   // write with auto precharge total delay before reuse
   task automatic ap_write_gap();
      repeat (AP_WRITE_TOTAL_DELAY) @(negedge mem_clk_o);
   endtask
endmodule

//--- ddrtim_pkg.sv
// ddrtim_pkg.sv: constants and types of the dram command timing block
// assumes a 100 MHz core clock sampling the memory clock pin
package ddrtim_pkg;
   // ----------------------------------------------------------------
   // timing, in ns and in core cycles
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS          = 10;
   localparam int ACT_TO_PRE_MIN_NS      = 45;
   localparam int ACT_TO_PRE_MIN_CYC     =
      (ACT_TO_PRE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_TO_PRE_NS           = 8;   // 7.5 ns rounded up in whole ns
   localparam int RD_TO_PRE_CYC          =
      (RD_TO_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W                  = 8;
   // termination off delay, counted in memory clock half periods
   localparam logic [2:0] TERM_OFF_HALVES = 3'h5;
   // ----------------------------------------------------------------
   // command encodings, {ras_n, cas_n, we_n}
   // ----------------------------------------------------------------
   localparam logic [2:0] CMD_ACT  = 3'h3;
   localparam logic [2:0] CMD_RD   = 3'h5;
   localparam logic [2:0] CMD_WR   = 3'h4;
   localparam logic [2:0] CMD_PRE  = 3'h2;
   localparam logic [2:0] CMD_REF  = 3'h1;
   localparam logic [2:0] CMD_MRS  = 3'h0;
   // ----------------------------------------------------------------
   // address fields
   // ----------------------------------------------------------------
   localparam int ADDR_AP_BIT   = 10;
   localparam int TERM_HI_BIT   = 6;
   localparam int TERM_LO_BIT   = 2;
   localparam logic [2:0] BANK_EXT = 3'h1;

   // termination resistance selects
   typedef enum logic [1:0] {
      DDRTIM_TERM_OFF = 2'h0,
      DDRTIM_TERM_75  = 2'h1,
      DDRTIM_TERM_150 = 2'h2,
      DDRTIM_TERM_50  = 2'h3
   } ddrtim_term_t;

   // command pins sampled together
   typedef struct packed {
      logic        cs_n;
      logic [2:0]  cmd;
      logic [2:0]  bank;
      logic [13:0] addr;
   } ddrtim_cmd_t;
endpackage
